/* design/pm5_pkg.sv */
// Constants shared by the port 5 bus control pin multiplexer
package pm5_pkg;

  // ==========================================================
  // Register map (byte addresses, one 32-bit word each)
  localparam logic [11:0] OFF_CTRL     = 12'h000;
  localparam logic [11:0] OFF_DATA     = 12'h004;
  localparam logic [11:0] OFF_DIR      = 12'h008;
  localparam logic [11:0] OFF_PIN      = 12'h00C;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h010;
  localparam logic [11:0] OFF_IRQ_EN   = 12'h014;
  localparam logic [11:0] OFF_IRQ_CLR  = 12'h018;

  // ==========================================================
  // Control register fields
  localparam int CTRL_READY_EN = 0;
  localparam int CTRL_HOLD_EN  = 1;
  localparam int CTRL_BUS16    = 2;
  localparam int CTRL_WRH_EN   = 3;
  localparam int CTRL_WRL_EN   = 4;
  localparam int CTRL_RD_EN    = 5;
  localparam int CTRL_FLASH    = 6;
  localparam int CTRL_W        = 7;

  // ==========================================================
  // Line numbering and widths
  localparam int LINE_LO = 1;
  localparam int LINE_HI = 7;
  localparam int LINE_W  = 7;

  // ==========================================================
  // Event bits of the interrupt registers
  localparam int EVT_HOLD_REQ = 0;
  localparam int EVT_LINE7    = 1;
  localparam int EVT_FL_WRITE = 2;
  localparam int EVT_W        = 3;

  // ==========================================================
  // Reset values
  localparam logic [CTRL_W-1:0] RST_CTRL   = 7'h00;
  localparam logic [LINE_W-1:0] RST_DATA   = 7'h00;
  localparam logic [LINE_W-1:0] RST_DIR    = 7'h00;
  localparam logic [EVT_W-1:0]  RST_IRQ_EN = 3'h0;

endpackage : pm5_pkg

/* design/pm5_edge_det.sv */
// Rising edge detector for the interrupt event levels
`timescale 1ns/1ps
`default_nettype none

module pm5_edge_det (
  input  wire logic                        clk_i,    // System clock
  input  wire logic                        rst_n_i,  // Sync reset, active low
  input  wire logic [pm5_pkg::EVT_W-1:0]   lvl_i,    // Event levels
  output logic      [pm5_pkg::EVT_W-1:0]   rise_o    // One-cycle rise pulses
);

  typedef struct packed {
    logic [pm5_pkg::EVT_W-1:0] prev;
    logic [pm5_pkg::EVT_W-1:0] rise;
  } pm5_edge_state_t;

  pm5_edge_state_t state;
  pm5_edge_state_t next_state;

  // ==========================================================
  // Per-bit edge logic
  always_comb begin
    next_state      = state;
    next_state.prev = lvl_i;
    for (int i = 0; i < pm5_pkg::EVT_W; i++) begin
      next_state.rise[i] = lvl_i[i] & ~state.prev[i];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rise_o = state.rise;

endmodule : pm5_edge_det
`default_nettype wire

/* design/pm5_irq.sv */
// Sticky interrupt status with enable and write-one clear
`timescale 1ns/1ps
`default_nettype none

module pm5_irq (
  input  wire logic                        clk_i,    // System clock
  input  wire logic                        rst_n_i,  // Sync reset, active low
  input  wire logic [pm5_pkg::EVT_W-1:0]   set_i,    // Event pulses
  input  wire logic [pm5_pkg::EVT_W-1:0]   clr_i,    // Clear pulses
  input  wire logic [pm5_pkg::EVT_W-1:0]   en_i,     // Enable mask
  output logic      [pm5_pkg::EVT_W-1:0]   stat_o,   // Sticky status
  output logic                             irq_o     // Level interrupt
);

  typedef struct packed {
    logic [pm5_pkg::EVT_W-1:0] stat;
    logic                      irq;
  } pm5_irq_state_t;

  pm5_irq_state_t state;
  pm5_irq_state_t next_state;

  // ==========================================================
  // Set beats clear so an event in the clear cycle is kept
  always_comb begin
    next_state      = state;
    next_state.stat = (state.stat & ~clr_i) | set_i;
    next_state.irq  = |(next_state.stat & en_i);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign stat_o = state.stat;
  assign irq_o  = state.irq;

endmodule : pm5_irq
`default_nettype wire

/* design/pm5_pin_mux.sv */
// Port 5 lines 1 to 7: function select between port bits and bus control
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module pm5_pin_mux (
  input  wire logic        clk_i,             // System clock, 100 MHz
  input  wire logic        rst_n_i,           // Sync reset, active low
  // APB slave
  input  wire logic        psel_i,            // Slave select
  input  wire logic        penable_i,         // Access phase
  input  wire logic        pwrite_i,          // Write when high
  input  wire logic [11:0] paddr_i,           // Byte address
  input  wire logic [31:0] pwdata_i,          // Write data
  output logic      [31:0] prdata_o,          // Read data
  output logic             pready_o,          // Transfer done
  output logic             pslverr_o,         // Unmapped address
  // Pads, index is the line number
  input  wire logic [7:1]  pad_in_i,          // Pad levels
  output logic      [7:1]  pad_out_o,         // Pad drive value
  output logic      [7:1]  pad_oe_o,          // Pad drive enable
  // Bus controller side
  input  wire logic        hold_grant_i,      // Hold granted
  input  wire logic        upper_wr_n_i,      // Upper byte write strobe
  input  wire logic        lower_wr_n_i,      // Lower byte write strobe
  input  wire logic        rd_n_i,            // Read strobe
  output logic             bus_ready_o,       // Ready to bus controller
  output logic             hold_req_o,        // Hold request to bus controller
  // Capture, interrupt and flash units
  output logic             capture_ch3_o,     // Line 7 to capture channel 3
  output logic             ext_irq_ch3_o,     // Line 7 to interrupt channel 3
  output logic             flash_we_n_o,      // Flash write enable
  output logic             flash_oe_n_o,      // Flash output enable
  output logic             flash_ce_n_o,      // Flash chip enable
  output logic             flash_byte_o,      // Flash byte/word select
  output logic             irq_o              // Interrupt, active high
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [pm5_pkg::CTRL_W-1:0] ctrl;
    logic [pm5_pkg::LINE_W-1:0] data;
    logic [pm5_pkg::LINE_W-1:0] dir;
    logic [pm5_pkg::EVT_W-1:0]  irq_en;
    logic [pm5_pkg::EVT_W-1:0]  irq_clr;
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
    logic [7:1]                 pad_out;
    logic [7:1]                 pad_oe;
    logic                       bus_ready;
    logic                       hold_req;
    logic                       cap3;
    logic                       eirq3;
    logic                       fl_we_n;
    logic                       fl_oe_n;
    logic                       fl_ce_n;
    logic                       fl_byte;
  } pm5_state_t;

  pm5_state_t state;
  pm5_state_t next_state;

  logic [pm5_pkg::EVT_W-1:0] evt_lvl;
  logic [pm5_pkg::EVT_W-1:0] evt_rise;
  logic [pm5_pkg::EVT_W-1:0] irq_stat;
  logic                      irq_line;

  // ==========================================================
  // Address decode helper
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
    hit = (addr == off);
  endfunction : hit

  function automatic logic mapped(input logic [11:0] addr);
    mapped = hit(addr, pm5_pkg::OFF_CTRL) | hit(addr, pm5_pkg::OFF_DATA)
           | hit(addr, pm5_pkg::OFF_DIR) | hit(addr, pm5_pkg::OFF_PIN)
           | hit(addr, pm5_pkg::OFF_IRQ_STAT) | hit(addr, pm5_pkg::OFF_IRQ_EN)
           | hit(addr, pm5_pkg::OFF_IRQ_CLR);
  endfunction : mapped

  // ==========================================================
  // Event sources
  // Flash write cycle is seen as chip enable and write enable both low
  assign evt_lvl[pm5_pkg::EVT_HOLD_REQ] = state.hold_req;
  assign evt_lvl[pm5_pkg::EVT_LINE7]    = state.cap3;
  assign evt_lvl[pm5_pkg::EVT_FL_WRITE] = state.ctrl[pm5_pkg::CTRL_FLASH]
                                          & ~state.fl_we_n & ~state.fl_ce_n;

  pm5_edge_det u_edge (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .lvl_i   (evt_lvl),
    .rise_o  (evt_rise)
  );

  pm5_irq u_irq (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .set_i   (evt_rise),
    .clr_i   (state.irq_clr),
    .en_i    (state.irq_en),
    .stat_o  (irq_stat),
    .irq_o   (irq_line)
  );

  // ==========================================================
  // Next state
  always_comb begin
    logic ready_en;
    logic hold_en;
    logic bus16;
    logic wrh_en;
    logic wrl_en;
    logic rd_en;
    logic flash;
    logic acc;
    logic [31:0] rd;
    ready_en = state.ctrl[pm5_pkg::CTRL_READY_EN];
    hold_en  = state.ctrl[pm5_pkg::CTRL_HOLD_EN];
    bus16    = state.ctrl[pm5_pkg::CTRL_BUS16];
    wrh_en   = state.ctrl[pm5_pkg::CTRL_WRH_EN];
    wrl_en   = state.ctrl[pm5_pkg::CTRL_WRL_EN];
    rd_en    = state.ctrl[pm5_pkg::CTRL_RD_EN];
    flash    = state.ctrl[pm5_pkg::CTRL_FLASH];
    acc      = psel_i & penable_i;
    rd       = 32'h0000_0000;
    next_state = state;
    next_state.irq_clr = '0;

    // ========================================================
    // APB: one wait state, then pready for one cycle
    next_state.pready  = acc & ~state.pready;
    next_state.pslverr = acc & ~state.pready & ~mapped(paddr_i);
    if (acc & ~state.pready & ~pwrite_i) begin
      unique case (1'b1)
        hit(paddr_i, pm5_pkg::OFF_CTRL):     rd[pm5_pkg::CTRL_W-1:0] = state.ctrl;
        hit(paddr_i, pm5_pkg::OFF_DATA):     rd[7:1] = state.data;
        hit(paddr_i, pm5_pkg::OFF_DIR):      rd[7:1] = state.dir;
        hit(paddr_i, pm5_pkg::OFF_PIN):      rd[7:1] = pad_in_i;
        hit(paddr_i, pm5_pkg::OFF_IRQ_STAT): rd[pm5_pkg::EVT_W-1:0] = irq_stat;
        hit(paddr_i, pm5_pkg::OFF_IRQ_EN):   rd[pm5_pkg::EVT_W-1:0] = state.irq_en;
        default:                             rd = 32'h0000_0000;
      endcase
      next_state.prdata = rd;
    end
    if (acc & state.pready & pwrite_i) begin
      if (hit(paddr_i, pm5_pkg::OFF_CTRL)) begin
        next_state.ctrl = pwdata_i[pm5_pkg::CTRL_W-1:0];
      end
      if (hit(paddr_i, pm5_pkg::OFF_DATA)) begin
        next_state.data = pwdata_i[7:1];
      end
      if (hit(paddr_i, pm5_pkg::OFF_DIR)) begin
        next_state.dir = pwdata_i[7:1];
      end
      if (hit(paddr_i, pm5_pkg::OFF_IRQ_EN)) begin
        next_state.irq_en = pwdata_i[pm5_pkg::EVT_W-1:0];
      end
      if (hit(paddr_i, pm5_pkg::OFF_IRQ_CLR)) begin
        next_state.irq_clr = pwdata_i[pm5_pkg::EVT_W-1:0];
      end
    end

    // ========================================================
    // Pin function select
    // Default port control
    next_state.pad_out = state.data;
    next_state.pad_oe  = state.dir;

    if (ready_en) begin
      next_state.pad_oe[1] = 1'b0;
    end
    next_state.bus_ready = ready_en ? pad_in_i[1] : 1'b1;

    if (hold_en) begin
      next_state.pad_out[2] = hold_grant_i;
      next_state.pad_oe[2]  = 1'b1;
    end

    if (hold_en) begin
      next_state.pad_oe[3] = 1'b0;
    end
    next_state.hold_req = hold_en & pad_in_i[3];

    if (bus16 & wrh_en) begin
      next_state.pad_out[4] = upper_wr_n_i;
      next_state.pad_oe[4]  = 1'b1;
    end

    if (wrl_en) begin
      next_state.pad_out[5] = lower_wr_n_i;
      next_state.pad_oe[5]  = 1'b1;
    end

    if (rd_en) begin
      next_state.pad_out[6] = rd_n_i;
      next_state.pad_oe[6]  = 1'b1;
    end

    // Flash command inputs
    // Flash mode overrides bus strobes so the programmer never fights a driver
    if (flash) begin
      next_state.pad_oe[6:4] = 3'h0;
    end
    next_state.fl_we_n = flash ? pad_in_i[4] : 1'b1;
    next_state.fl_oe_n = flash ? pad_in_i[5] : 1'b1;
    next_state.fl_ce_n = flash ? pad_in_i[6] : 1'b1;

    if (flash) begin
      next_state.pad_oe[7] = 1'b0;
    end
    next_state.fl_byte = flash & pad_in_i[7];

    // Line 7 always sampled
    // Only the port direction bit can drive line 7; software must leave it clear
    next_state.cap3  = pad_in_i[7];
    next_state.eirq3 = pad_in_i[7];
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state           <= '0;
      state.ctrl      <= pm5_pkg::RST_CTRL;
      state.data      <= pm5_pkg::RST_DATA;
      state.dir       <= pm5_pkg::RST_DIR;
      state.irq_en    <= pm5_pkg::RST_IRQ_EN;
      state.bus_ready <= 1'b1;
      state.fl_we_n   <= 1'b1;
      state.fl_oe_n   <= 1'b1;
      state.fl_ce_n   <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata_o      = state.prdata;
  assign pready_o      = state.pready;
  assign pslverr_o     = state.pslverr;
  assign pad_out_o     = state.pad_out;
  assign pad_oe_o      = state.pad_oe;
  assign bus_ready_o   = state.bus_ready;
  assign hold_req_o    = state.hold_req;
  assign capture_ch3_o = state.cap3;
  assign ext_irq_ch3_o = state.eirq3;
  assign flash_we_n_o  = state.fl_we_n;
  assign flash_oe_n_o  = state.fl_oe_n;
  assign flash_ce_n_o  = state.fl_ce_n;
  assign flash_byte_o  = state.fl_byte;
  assign irq_o         = irq_line;

endmodule : pm5_pin_mux
`default_nettype wire

/* tb/pm5_ext_model.sv */
// Far-side pad model: programmer, hold requester and bus devices
`timescale 1ns/1ps
`default_nettype none

module pm5_ext_model (
  input  wire logic       clk_i,  // System clock
  input  wire logic [7:1] oe_i,   // Device drive enable
  input  wire logic [7:1] out_i,  // Device drive value
  input  wire logic [7:1] en_i,   // Lines this side drives
  input  wire logic [7:1] val_i,  // Value this side drives
  output logic      [7:1] pad_o   // Resolved pad level
);
  // ==========
  // Pad resolution
  // No pulls on these pads, so a free line changes every cycle
  logic [7:1] flt = 7'h55;

  always_ff @(posedge clk_i) begin
    flt <= ~flt;
  end

  // drive only lines the device leaves free
  always_comb begin
    for (int i = 1; i <= 7; i++) begin
      pad_o[i] = oe_i[i] ? out_i[i] : (en_i[i] ? val_i[i] : flt[i]);
    end
  end
endmodule : pm5_ext_model
`default_nettype wire

/* tb/pm5_pin_mux_asserts.sv */
// Port-level checker for the port 5 pin multiplexer
`timescale 1ns/1ps
`default_nettype none

module pm5_pin_mux_asserts (
  input wire logic        clk_i,         // Clock
  input wire logic        rst_n_i,       // Reset
  input wire logic        psel_i,        // Select
  input wire logic        penable_i,     // Access
  input wire logic        pwrite_i,      // Write
  input wire logic [11:0] paddr_i,       // Address
  input wire logic [31:0] pwdata_i,      // Write data
  input wire logic        pready_o,      // Done
  input wire logic [7:1]  pad_in_i,      // Pad levels
  input wire logic [7:1]  pad_out_o,     // Pad value
  input wire logic [7:1]  pad_oe_o,      // Pad enable
  input wire logic        hold_grant_i,  // Grant
  input wire logic        upper_wr_n_i,  // Upper strobe
  input wire logic        lower_wr_n_i,  // Lower strobe
  input wire logic        rd_n_i,        // Read strobe
  input wire logic        bus_ready_o,   // Ready
  input wire logic        hold_req_o,    // Hold request
  input wire logic        capture_ch3_o, // Capture feed
  input wire logic        ext_irq_ch3_o, // Interrupt feed
  input wire logic        flash_we_n_o,  // Flash write
  input wire logic        flash_oe_n_o,  // Flash output
  input wire logic        flash_ce_n_o,  // Flash chip
  input wire logic        flash_byte_o   // Flash width
);
  // ==========
  // Shadow of the control, data and direction words
  logic [6:0] sc;
  logic [7:1] sd;
  logic [7:1] sr;
  logic [7:1] eo;
  logic [7:1] ev;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sc <= 7'h00;
      sd <= 7'h00;
      sr <= 7'h00;
    end else if (psel_i && penable_i && pready_o && pwrite_i) begin
      if (paddr_i == pm5_pkg::OFF_CTRL) sc <= pwdata_i[6:0];
      if (paddr_i == pm5_pkg::OFF_DATA) sd <= pwdata_i[7:1];
      if (paddr_i == pm5_pkg::OFF_DIR) sr <= pwdata_i[7:1];
    end
  end

  assign eo = {!sc[6] && sr[7], !sc[6] && (sc[5] || sr[6]), !sc[6] && (sc[4] || sr[5]),
               !sc[6] && ((sc[2] && sc[3]) || sr[4]), !sc[1] && sr[3], sc[1] || sr[2],
               !sc[0] && sr[1]};
  assign ev = {sd[7], sc[5] ? rd_n_i : sd[6], sc[4] ? lower_wr_n_i : sd[5],
               (sc[2] && sc[3]) ? upper_wr_n_i : sd[4], sd[3],
               sc[1] ? hold_grant_i : sd[2], sd[1]};

  // ==========
  // Assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_setup;
    psel_i && !penable_i ##1 psel_i && penable_i;
  endsequence
  sequence s_answer;
    !pready_o ##1 pready_o;
  endsequence
  property p_line(int i);
    $past(rst_n_i) |-> pad_oe_o[i] == $past(eo[i]) && (!$past(eo[i])
      || pad_out_o[i] == $past(ev[i]));
  endproperty

  a_apb_answer: assert property (s_setup |-> s_answer)
    else $error("access phase length wrong");
  a_ready_route: assert property ($past(rst_n_i) |-> bus_ready_o ==
    $past(sc[0] ? pad_in_i[1] : 1'b1)) else $error("ready input route wrong");
  a_hold_grant: assert property (p_line(2)) else $error("line 2 wrong");
  a_hold_req: assert property ($past(rst_n_i) |-> hold_req_o ==
    $past(sc[1] & pad_in_i[3])) else $error("hold request route wrong");
  a_hold_pin: assert property (p_line(3)) else $error("line 3 wrong");
  a_upper_strobe: assert property (p_line(4)) else $error("line 4 wrong");
  a_lower_strobe: assert property (p_line(5)) else $error("line 5 wrong");
  a_read_strobe: assert property (p_line(6)) else $error("line 6 wrong");
  a_flash_ctrl: assert property ($past(rst_n_i) |-> {flash_ce_n_o, flash_oe_n_o,
    flash_we_n_o} == $past(sc[6] ? pad_in_i[6:4] : 3'h7)) else $error("flash controls wrong");
  a_flash_byte: assert property ($past(rst_n_i) |-> flash_byte_o ==
    $past(sc[6] & pad_in_i[7])) else $error("flash width wrong");
  a_line7_feed: assert property ($past(rst_n_i) |-> capture_ch3_o ==
    $past(pad_in_i[7]) && $stable(capture_ch3_o ^ ext_irq_ch3_o)) else $error("line 7 feed wrong");
  a_line7_drive: assert property (p_line(7)) else $error("line 7 wrong");
  a_port_return: assert property (p_line(1)) else $error("line 1 wrong");
endmodule : pm5_pin_mux_asserts

bind pm5_pin_mux pm5_pin_mux_asserts i_pm5_pin_mux_asserts (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
  .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
  .hold_grant_i(hold_grant_i), .upper_wr_n_i(upper_wr_n_i), .lower_wr_n_i(lower_wr_n_i),
  .rd_n_i(rd_n_i), .bus_ready_o(bus_ready_o), .hold_req_o(hold_req_o),
  .capture_ch3_o(capture_ch3_o), .ext_irq_ch3_o(ext_irq_ch3_o), .flash_we_n_o(flash_we_n_o),
  .flash_oe_n_o(flash_oe_n_o), .flash_ce_n_o(flash_ce_n_o), .flash_byte_o(flash_byte_o)
);
`default_nettype wire

/* tb/test_pm5_pin_mux.sv */
// Self-checking testbench for the port 5 pin multiplexer
`timescale 1ns/1ps
`default_nettype none

module test_pm5_pin_mux;
  logic        clk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o;
  logic        hold_grant_i, upper_wr_n_i, lower_wr_n_i, rd_n_i, bus_ready_o, hold_req_o;
  logic        capture_ch3_o, ext_irq_ch3_o, flash_we_n_o, flash_oe_n_o, flash_ce_n_o;
  logic        flash_byte_o, er_v;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd_v, lf;
  logic [7:1]  pad_in_i, pad_out_o, pad_oe_o, xval, d, r;
  logic [6:0]  c;
  logic [13:0] e;
  int          num_errors, check_count, cyc;

  pm5_pin_mux i_pm5_pin_mux (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .pad_in_i(pad_in_i),
    .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .hold_grant_i(hold_grant_i),
    .upper_wr_n_i(upper_wr_n_i), .lower_wr_n_i(lower_wr_n_i), .rd_n_i(rd_n_i),
    .bus_ready_o(bus_ready_o), .hold_req_o(hold_req_o), .capture_ch3_o(capture_ch3_o),
    .ext_irq_ch3_o(ext_irq_ch3_o), .flash_we_n_o(flash_we_n_o), .flash_oe_n_o(flash_oe_n_o),
    .flash_ce_n_o(flash_ce_n_o), .flash_byte_o(flash_byte_o), .irq_o(irq_o));
  pm5_ext_model i_pm5_ext_model (.clk_i(clk_i), .oe_i(pad_oe_o), .out_i(pad_out_o),
    .en_i(7'h7F), .val_i(xval), .pad_o(pad_in_i));

  // ==========
  // Helpers
  always #5 clk_i = ~clk_i;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Expected pad enables (high half) and driven values (low half, masked)
  function automatic logic [13:0] pads(input logic [6:0] k, input logic [7:1] dt, dr);
    logic [7:1] o;
    logic [7:1] v;
    o = {!k[6] && dr[7], !k[6] && (k[5] || dr[6]), !k[6] && (k[4] || dr[5]),
         !k[6] && ((k[2] && k[3]) || dr[4]), !k[1] && dr[3], k[1] || dr[2], !k[0] && dr[1]};
    v = {dt[7], k[5] ? rd_n_i : dt[6], k[4] ? lower_wr_n_i : dt[5],
         (k[2] && k[3]) ? upper_wr_n_i : dt[4], dt[3], k[1] ? hold_grant_i : dt[2], dt[1]};
    return {o, o & v};
  endfunction : pads

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Called just after a rising edge; one idle edge follows each transfer
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
    int n;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= dat;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n == 20) num_errors++;
    rd_v = prdata_o;
    er_v = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask : apb

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      end_sim();
    end
  end

  // ==========
  // Main sequence
  initial begin
    {clk_i, psel_i, penable_i, pwrite_i, rst_n_i} = '0;
    {hold_grant_i, upper_wr_n_i, lower_wr_n_i, rd_n_i} = 4'hF;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    xval = 7'h00;
    lf = 32'hB;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    for (int k = 0; k < 40; k++) begin
      lf = lfsr(lfsr(lf));
      c = (k < 7) ? 7'(1 << k) : ((k == 7) ? 7'h0C : lf[6:0]);
      d = lf[13:7];
      r = lf[20:14];
      apb(1'b1, pm5_pkg::OFF_CTRL, {25'h0, c});
      apb(1'b1, pm5_pkg::OFF_DATA, {24'h0, d, 1'b0});
      apb(1'b1, pm5_pkg::OFF_DIR, {24'h0, r, 1'b0});
      xval <= lf[27:21];
      {hold_grant_i, upper_wr_n_i, lower_wr_n_i, rd_n_i} <= lf[31:28];
      repeat (3) @(posedge clk_i);
      e = pads(c, d, r);
      chk(pad_oe_o, e[13:7]);
      chk(pad_out_o & e[13:7], e[6:0]);
      chk(bus_ready_o, c[0] ? pad_in_i[1] : 1'b1);
      chk(hold_req_o, c[1] & pad_in_i[3]);
      chk({flash_ce_n_o, flash_oe_n_o, flash_we_n_o}, c[6] ? pad_in_i[6:4] : 3'h7);
      chk(flash_byte_o, c[6] & pad_in_i[7]);
      chk({capture_ch3_o, ext_irq_ch3_o}, {2{pad_in_i[7]}});
    end
    // Second reset in mid-run, then reset values and an unmapped place
    rst_n_i <= 1'b0;
    xval <= 7'h00;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, 12'(k * 4), 32'h0);
      // Error flag and data are compared apart: the check task is one word wide
      chk(rd_v, 32'h0);
      chk(32'(er_v), 32'h0);
    end
    apb(1'b0, 12'h01C, 32'h0);
    chk(rd_v, 32'h0);
    chk(32'(er_v), 32'h1);
    // Interrupt: raise, mask, unmask, clear
    apb(1'b1, pm5_pkg::OFF_IRQ_CLR, 32'h7);
    apb(1'b1, pm5_pkg::OFF_IRQ_EN, 32'(1 << pm5_pkg::EVT_LINE7));
    xval <= 7'h40;
    repeat (5) @(posedge clk_i);
    chk(irq_o, 1'b1);
    apb(1'b1, pm5_pkg::OFF_IRQ_EN, 32'h0);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b0);
    apb(1'b0, pm5_pkg::OFF_IRQ_STAT, 32'h0);
    chk(rd_v, 32'(1 << pm5_pkg::EVT_LINE7));
    apb(1'b1, pm5_pkg::OFF_IRQ_EN, 32'(1 << pm5_pkg::EVT_LINE7));
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b1);
    apb(1'b1, pm5_pkg::OFF_IRQ_CLR, 32'(1 << pm5_pkg::EVT_LINE7));
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b0);
    apb(1'b0, pm5_pkg::OFF_IRQ_STAT, 32'h0);
    chk(rd_v, 32'h0);
    end_sim();
  end
endmodule : test_pm5_pin_mux
`default_nettype wire
